// *** hw/dsc_ctrl.sv ***
/*
  Control logic of a dual high-side switch: serial command port, channel
  switching from direct input, internal or external time base, fail-safe on
  host silence, fault signalling, sense selection and an APB register file.
  Assumes all pins except APB and fault_det_i are asynchronous to clk_i.
*/
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module dsc_ctrl #(
  parameter int WDOG_CYCLES = dsc_pkg::WDOG_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  // Serial command port.
  input wire logic sclk_i,
  input wire logic si_i,
  input wire logic chip_sel_n_i,
  output logic so_o,
  output logic so_oe_o,
  // Device pins.
  input wire logic [1:0] direct_in_i,
  input wire logic [1:0] oc_profile_sel_i,
  input wire logic pwm_clk_i,
  input wire logic reset_in_n_i,
  // Protection detectors, one per channel.
  input wire logic [1:0] fault_det_i,
  // Channel and sense controls.
  output logic [1:0] switch_out_o,
  output logic [1:0] oc_profile_o,
  output logic sense_out_temp_o,
  output logic sense_out_hi_o,
  output logic sleep_o,
  // Open-drain indicators.
  input wire logic failsafe_ind_n_i,
  output logic failsafe_ind_n_o,
  output logic failsafe_ind_n_oe_o,
  input wire logic fault_ind_n_i,
  output logic fault_ind_n_o,
  output logic fault_ind_n_oe_o,
  input wire logic sense_sync_n_i,
  output logic sense_sync_n_o,
  output logic sense_sync_n_oe_o
);

  if (WDOG_CYCLES < 2) begin : g_chk
    $error("WDOG_CYCLES must be at least 2");
  end

  localparam logic [31:0] WDOG_LAST = 32'(WDOG_CYCLES - 1);

  dsc_pkg::dsc_state_t st;
  dsc_pkg::dsc_state_t next_st;

  logic [8:0] pins_s;
  logic [1:0] in_s;
  logic [1:0] conf_s;
  logic sclk_s;
  logic si_s;
  logic cs_s;
  logic pwm_s;
  logic pin_rst;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic pwm_rise;
  logic frame_ok;
  logic apb_wr;
  logic int_tick;
  logic [15:0] reply;
  logic [3:0] ev;
  logic [1:0] want;

  // All input pins but APB, fault_det_i and the open-drain indicator inputs pass two flops first; the external PWM clock among them.
  // Reset values are the idle pin levels, so no false edge follows reset.
  dsc_sync2 #(
    .W(9),
    .RST_VAL(9'h140)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({reset_in_n_i, pwm_clk_i, chip_sel_n_i, si_i, sclk_i, oc_profile_sel_i, direct_in_i}),
    .q_o(pins_s)
  );

  assign in_s = pins_s[1:0];
  assign conf_s = pins_s[3:2];
  assign sclk_s = pins_s[4];
  assign si_s = pins_s[5];
  assign cs_s = pins_s[6];
  assign pwm_s = pins_s[7];
  assign pin_rst = ~pins_s[8];

  assign cs_fall = st.cs_q & ~cs_s;
  assign cs_rise = ~st.cs_q & cs_s;
  assign sclk_rise = ~st.sclk_q & sclk_s;
  assign pwm_rise = ~st.pwm_q & pwm_s;
  assign frame_ok = cs_rise & (st.bitcnt == dsc_pkg::FRAME_BITS);
  assign apb_wr = psel_i & penable_i & pwrite_i;
  assign int_tick = st.tick_cnt == dsc_pkg::INT_TICK_CYCLES - 6'h01;
  assign reply = {st.fault, st.failsafe, st.sleep, st.sw, st.oc, st.int_stat, 4'h0};

  always_comb begin
    next_st = st;
    ev = 4'h0;
    want = 2'h0;
    next_st.sclk_q = sclk_s;
    next_st.cs_q = cs_s;
    next_st.pwm_q = pwm_s;
    // Serial shift: load the reply at select, shift on each clock rise.
    if (cs_fall) begin
      next_st.shreg = reply;
      next_st.bitcnt = 5'h00;
    end else if (!cs_s && sclk_rise) begin
      next_st.shreg = {st.shreg[14:0], si_s};
      if (st.bitcnt <= dsc_pkg::FRAME_BITS) begin
        next_st.bitcnt = st.bitcnt + 5'h01;
      end
    end
    if (frame_ok) begin
      next_st.ctrl = st.shreg;
      next_st.last_frame = st.shreg;
      ev[dsc_pkg::INT_FRAME_OK] = 1'b1;
    end else if (cs_rise) begin
      ev[dsc_pkg::INT_FRAME_ERR] = 1'b1;
    end
    // Host silence watchdog; only a good frame feeds it.
    if (frame_ok) begin
      next_st.wdog = 32'h0000_0000;
      next_st.failsafe = 1'b0;
    end else if (!st.failsafe) begin
      if (st.wdog == WDOG_LAST) begin
        next_st.failsafe = 1'b1;
        next_st.wdog = 32'h0000_0000;
        ev[dsc_pkg::INT_FAILSAFE] = 1'b1;
      end else begin
        next_st.wdog = st.wdog + 32'h0000_0001;
      end
    end
    // Time bases: a free internal tick, or the synchronised external edge.
    next_st.tick_cnt = int_tick ? 6'h00 : st.tick_cnt + 6'h01;
    if ((st.ctrl.mode0 == dsc_pkg::MODE_INT_CLK && int_tick) ||
        (st.ctrl.mode0 == dsc_pkg::MODE_EXT_CLK && pwm_rise)) begin
      next_st.pwm0 = st.pwm0 + 4'h1;
    end
    if ((st.ctrl.mode1 == dsc_pkg::MODE_INT_CLK && int_tick) ||
        (st.ctrl.mode1 == dsc_pkg::MODE_EXT_CLK && pwm_rise)) begin
      next_st.pwm1 = st.pwm1 + 4'h1;
    end
    // An open direct input reads low through its pull-down, so direct control keeps it off.
    unique case (st.ctrl.mode0)
      dsc_pkg::MODE_DIRECT: want[0] = in_s[0];
      dsc_pkg::MODE_INT_CLK, dsc_pkg::MODE_EXT_CLK: want[0] = st.pwm0 < st.ctrl.duty0;
      dsc_pkg::MODE_OFF: want[0] = 1'b0;
    endcase
    unique case (st.ctrl.mode1)
      dsc_pkg::MODE_DIRECT: want[1] = in_s[1];
      dsc_pkg::MODE_INT_CLK, dsc_pkg::MODE_EXT_CLK: want[1] = st.pwm1 < st.ctrl.duty1;
      dsc_pkg::MODE_OFF: want[1] = 1'b0;
    endcase
    // Fail-safe hands both channels to their direct inputs; faults force off.
    if (st.failsafe) begin
      want = in_s;
    end
    next_st.sw = want & ~st.fault & {2{~st.sleep}};
    // Sense settling restarts at every switching edge.
    if (next_st.sw != st.sw) begin
      next_st.settle = 16'h0000;
    end else if (st.settle != dsc_pkg::SETTLE_CYCLES) begin
      next_st.settle = st.settle + 16'h0001;
    end
    next_st.oc = conf_s;
    next_st.sleep = pin_rst & ~|in_s;
    // Faults latch; a new detection wins over a clear in the same cycle.
    next_st.fault = st.fault;
    if (apb_wr && paddr_i == dsc_pkg::OFS_FAULT) begin
      next_st.fault = st.fault & ~pwdata_i[1:0];
    end
    next_st.fault = next_st.fault | fault_det_i;
    if (|(fault_det_i & ~st.fault)) begin
      ev[dsc_pkg::INT_FAULT] = 1'b1;
    end
    // Register writes.
    next_st.int_stat = st.int_stat;
    if (apb_wr) begin
      if (paddr_i == dsc_pkg::OFS_CTRL) begin
        next_st.ctrl = pwdata_i[15:0];
      end
      if (paddr_i == dsc_pkg::OFS_INT_STAT) begin
        next_st.int_stat = st.int_stat & ~pwdata_i[3:0];
      end
      if (paddr_i == dsc_pkg::OFS_INT_MASK) begin
        next_st.int_mask = pwdata_i[3:0];
      end
    end
    next_st.int_stat = next_st.int_stat | ev;
    // The reset pin restores configuration and faults and beats every other writer.
    if (pin_rst) begin
      next_st.ctrl = dsc_pkg::CTRL_RST;
      next_st.fault = 2'h0;
      next_st.int_mask = dsc_pkg::INT_MASK_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ctrl <= dsc_pkg::CTRL_RST;
      st.int_mask <= dsc_pkg::INT_MASK_RST;
      st.sclk_q <= 1'b0;
      st.cs_q <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // APB answers in the access phase with no wait state.
  always_comb begin
    prdata_o = 32'h0000_0000;
    pslverr_o = 1'b0;
    unique case (paddr_i)
      dsc_pkg::OFS_CTRL: prdata_o = {16'h0000, st.ctrl};
      dsc_pkg::OFS_STATUS: prdata_o = {24'h00_0000, st.oc, st.sw, st.sleep, st.fault != 2'h0, st.failsafe, cs_s};
      dsc_pkg::OFS_INT_STAT: prdata_o = {28'h000_0000, st.int_stat};
      dsc_pkg::OFS_INT_MASK: prdata_o = {28'h000_0000, st.int_mask};
      dsc_pkg::OFS_FRAME: prdata_o = {16'h0000, st.last_frame};
      dsc_pkg::OFS_FAULT: prdata_o = {30'h0000_0000, st.fault};
      default: pslverr_o = psel_i & penable_i;
    endcase
  end

  assign pready_o = 1'b1;
  assign irq_o = |(st.int_stat & st.int_mask);
  assign so_o = st.shreg[15];
  assign so_oe_o = ~cs_s;
  assign switch_out_o = st.sw;
  assign oc_profile_o = st.oc;
  assign sense_out_temp_o = st.ctrl.sense_temp;
  assign sense_out_hi_o = st.ctrl.sense_hi;
  assign sleep_o = st.sleep;
  assign failsafe_ind_n_o = 1'b0;
  assign failsafe_ind_n_oe_o = st.failsafe;
  assign fault_ind_n_o = 1'b0;
  assign fault_ind_n_oe_o = st.fault != 2'h0;
  assign sense_sync_n_o = 1'b0;
  assign sense_sync_n_oe_o = (st.sw != 2'h0) && (st.settle == dsc_pkg::SETTLE_CYCLES);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  short_frame_a: assert property (cs_rise && st.bitcnt != 5'h10 |=> $stable(st.last_frame))
    else $error("frame of wrong length was taken");
  wdog_expiry_a: assert property (!st.failsafe && st.wdog == WDOG_LAST && !frame_ok |=> st.failsafe)
    else $error("fail-safe not entered at watchdog expiry");
  failsafe_pin_a: assert property (!st.failsafe && st.wdog == WDOG_LAST && !frame_ok
    |=> failsafe_ind_n_oe_o && !failsafe_ind_n_o)
    else $error("fail-safe indicator not pulled low");
  fault_pin_a: assert property (fault_det_i != 2'h0 && !pin_rst |=> fault_ind_n_oe_o && !fault_ind_n_o)
    else $error("fault indicator not asserted");
  pin_reset_a: assert property (pin_rst |=> st.ctrl == dsc_pkg::CTRL_RST && st.fault == 2'h0)
    else $error("reset pin left configuration or faults");
  sleep_entry_a: assert property (pin_rst && in_s == 2'h0 |=> sleep_o ##1 switch_out_o == 2'h0)
    else $error("sleep not entered with inputs low");
  direct_follow_a: assert property (!st.failsafe && st.ctrl.mode0 == dsc_pkg::MODE_DIRECT
    && !st.fault[0] && !st.sleep |=> switch_out_o[0] == $past(in_s[0]))
    else $error("channel 0 does not follow its direct input");
  profile_pick_a: assert property (##2 oc_profile_o == $past(conf_s))
    else $error("overcurrent profile does not follow its pin");
  ext_tick_a: assert property (st.ctrl.mode1 == dsc_pkg::MODE_EXT_CLK && pwm_rise && !pin_rst
    |=> st.pwm1 == $past(st.pwm1) + 4'h1)
    else $error("external clock edge did not advance the time base");
  int_tick_a: assert property (st.ctrl.mode0 == dsc_pkg::MODE_INT_CLK && !int_tick && !frame_ok
    && !apb_wr |=> $stable(st.pwm0))
    else $error("internal time base moved without a tick");
  sync_drop_a: assert property (next_st.sw != st.sw |=> !sense_sync_n_oe_o [*2])
    else $error("sync pin held low across a switching edge");
  reply_load_a: assert property (cs_fall |=> so_o == $past(reply[15]) && so_oe_o)
    else $error("reply not presented on serial output");

endmodule // dsc_ctrl

// *** hw/dsc_pkg.sv ***
/*
  Shared constants and types of the dual switch control logic: register map,
  control word layout, reset values and timing counts.
  Assumes a 40 MHz system clock and a 32-bit APB register bus.
*/
package dsc_pkg;

  localparam int CLK_PERIOD_NS = 25;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0C;
  localparam logic [7:0] OFS_FRAME = 8'h10;
  localparam logic [7:0] OFS_FAULT = 8'h14;

  // Interrupt status bit positions.
  localparam int INT_FRAME_OK = 0;
  localparam int INT_FRAME_ERR = 1;
  localparam int INT_FAILSAFE = 2;
  localparam int INT_FAULT = 3;

  // Serial frame length in bits.
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // Host silence before fail-safe entry, and its count of cycles (longest time, rounded down).
  localparam int WDOG_TIMEOUT_NS = 1000000;
  localparam int WDOG_CYCLES = WDOG_TIMEOUT_NS / CLK_PERIOD_NS;
  // Settling time of the sense output after a switching edge (least time, rounded up).
  localparam int SETTLE_NS = 10000;
  localparam logic [15:0] SETTLE_CYCLES = 16'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Period of the internal PWM time-base tick.
  localparam int INT_TICK_NS = 1000;
  localparam logic [5:0] INT_TICK_CYCLES = 6'((INT_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_INT_CLK,
    MODE_EXT_CLK,
    MODE_OFF
  } dsc_mode_t;

  // Control word; the same layout is carried by a 16-bit serial frame.
  typedef struct packed {
    logic [1:0] spare;
    logic [3:0] duty1;
    logic [3:0] duty0;
    logic sense_hi;
    logic sense_temp;
    dsc_mode_t mode1;
    dsc_mode_t mode0;
  } dsc_ctrl_t;

  localparam dsc_ctrl_t CTRL_RST = 16'h0000;
  localparam logic [3:0] INT_MASK_RST = 4'h0;

  typedef struct packed {
    dsc_ctrl_t ctrl;
    logic [15:0] last_frame;
    logic [15:0] shreg;
    logic [4:0] bitcnt;
    logic sclk_q;
    logic cs_q;
    logic pwm_q;
    logic failsafe;
    logic [31:0] wdog;
    logic [5:0] tick_cnt;
    logic [3:0] pwm0;
    logic [3:0] pwm1;
    logic [1:0] sw;
    logic [1:0] fault;
    logic sleep;
    logic [1:0] oc;
    logic [15:0] settle;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
  } dsc_state_t;

endpackage

// *** hw/dsc_sync2.sv ***
/*
  Two-stage synchroniser for a vector of pin levels.
  Assumes each bit is a slow level or an edge far longer than two clock periods.
*/
`timescale 1ns/1ps
module dsc_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels.
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dsc_sync_st_t;

  dsc_sync_st_t st;
  dsc_sync_st_t next_st;

  always_comb begin
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= {RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.s2;

endmodule // dsc_sync2

// *** tb/dsc_ctrl_tb.sv ***
/*
  Self-checking testbench of the dual switch control logic.
  Assumes the serial host model and a shortened watchdog of 2000 cycles.
*/
`timescale 1ns/1ps
module dsc_ctrl_tb;
  logic clk_i, rst_i, psel, penable, pwrite, pwm_clk, reset_in_n, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d, on0, on1;
  logic pready, pslverr, irq, sclk, si, cs_n, so, so_oe;
  logic [1:0] direct_in, oc_sel, fault_det, sw, oc_prof;
  logic temp, hi, sleep, fs_o, fs_oe, ft_o, ft_oe, sy_o, sy_oe;
  logic [15:0] reply;
  int num_errors = 0;
  int n_tests = 0;
  // Open-drain pins with their pull-ups.
  wire logic fs_pin = fs_oe ? fs_o : 1'b1;
  wire logic ft_pin = ft_oe ? ft_o : 1'b1;
  wire logic sy_pin = sy_oe ? sy_o : 1'b1;
  // Serial output has no pull; while released it shows the inverse of its last level.
  wire logic so_pin = so_oe ? so : ~so;

  dsc_ctrl #(.WDOG_CYCLES(2000)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .irq_o(irq), .sclk_i(sclk), .si_i(si), .chip_sel_n_i(cs_n), .so_o(so), .so_oe_o(so_oe),
    .direct_in_i(direct_in), .oc_profile_sel_i(oc_sel), .pwm_clk_i(pwm_clk), .reset_in_n_i(reset_in_n),
    .fault_det_i(fault_det), .switch_out_o(sw), .oc_profile_o(oc_prof), .sense_out_temp_o(temp),
    .sense_out_hi_o(hi), .sleep_o(sleep), .failsafe_ind_n_i(fs_pin), .failsafe_ind_n_o(fs_o),
    .failsafe_ind_n_oe_o(fs_oe), .fault_ind_n_i(ft_pin), .fault_ind_n_o(ft_o), .fault_ind_n_oe_o(ft_oe),
    .sense_sync_n_i(sy_pin), .sense_sync_n_o(sy_o), .sense_sync_n_oe_o(sy_oe)
  );

  dsc_host_model host (.clk_i(clk_i), .so_i(so_pin), .sclk_o(sclk), .si_o(si), .chip_sel_n_o(cs_n));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i) penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, wd, rd, err);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic err;
    apb(1'b0, a, 32'h0, v, err);
    chk(what, exp, v);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #(20000 * 25);
    num_errors++;
    conclude();
  end

  initial begin
    rst_i = 1'b1;
    {psel, penable, pwrite, pwm_clk, e} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    reset_in_n = 1'b1;
    direct_in = 2'h0;
    oc_sel = 2'h0;
    fault_det = 2'h0;
    cyc(2);
    rst_i <= 1'b0;
    cyc(4);
    rd("ctrl reset", dsc_pkg::OFS_CTRL, 32'h0);
    rd("mask reset", dsc_pkg::OFS_INT_MASK, 32'h0);
    apb(1'b0, 8'h18, 32'h0, d, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
    oc_sel <= 2'h2;
    direct_in <= 2'h1;
    cyc(10);
    chk("profile", 32'h2, {30'h0, oc_prof});
    chk("direct switch", 32'h1, {30'h0, sw});
    chk("sync early", 32'h1, {31'h0, sy_pin});
    cyc(410);
    chk("sync settled", 32'h0, {31'h0, sy_pin});
    wr(dsc_pkg::OFS_INT_MASK, 32'hF);
    host.xfer(16'h2239, 16, reply);
    cyc(5);
    chk("reply", 32'h0600, {16'h0, reply});
    chk("so released", 32'h0, {31'h0, so_oe});
    rd("ctrl by frame", dsc_pkg::OFS_CTRL, 32'h2239);
    rd("frame", dsc_pkg::OFS_FRAME, 32'h2239);
    chk("sense select", 32'h3, {30'h0, hi, temp});
    chk("irq on", 32'h1, {31'h0, irq});
    wr(dsc_pkg::OFS_INT_STAT, 32'h1);
    cyc(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // Channel 0 runs on the internal tick, channel 1 on an external clock of 8 cycles.
    on0 = 32'h0;
    on1 = 32'h0;
    for (int c = 0; c < 640; c++) begin
      @(posedge clk_i);
      pwm_clk <= c[2];
      on0 = on0 + 32'(sw[0]);
      if (c[2:0] == 3'h3)
        on1 = on1 + 32'(sw[1]);
    end
    chk("internal duty", 32'h140, on0);
    chk("external duty", 32'h28, on1);
    host.xfer(16'h0000, 15, reply);
    cyc(5);
    rd("bad frame event", dsc_pkg::OFS_INT_STAT, 32'h2);
    rd("ctrl kept", dsc_pkg::OFS_CTRL, 32'h2239);
    wr(dsc_pkg::OFS_CTRL, 32'h0);
    fault_det <= 2'h1;
    @(posedge clk_i) fault_det <= 2'h0;
    cyc(3);
    chk("fault pin", 32'h0, {31'h0, ft_pin});
    chk("fault switch off", 32'h0, {31'h0, sw[0]});
    rd("fault reg", dsc_pkg::OFS_FAULT, 32'h1);
    rd("status", dsc_pkg::OFS_STATUS, 32'h85);
    wr(dsc_pkg::OFS_FAULT, 32'h3);
    wr(dsc_pkg::OFS_INT_STAT, 32'hF);
    wr(dsc_pkg::OFS_CTRL, 32'hF);
    cyc(3);
    chk("fault released", 32'h1, {31'h0, ft_pin});
    for (int i = 0; i < 2500 && fs_pin !== 1'b0; i++) @(posedge clk_i);
    chk("failsafe pin", 32'h0, {31'h0, fs_pin});
    rd("failsafe event", dsc_pkg::OFS_INT_STAT, 32'h4);
    direct_in <= 2'h3;
    cyc(6);
    chk("failsafe control", 32'h3, {30'h0, sw});
    reset_in_n <= 1'b0;
    direct_in <= 2'h0;
    cyc(8);
    chk("sleep", 32'h1, {31'h0, sleep});
    chk("sleep switches", 32'h0, {30'h0, sw});
    rd("ctrl pin reset", dsc_pkg::OFS_CTRL, 32'h0);
    rd("mask pin reset", dsc_pkg::OFS_INT_MASK, 32'h0);
    direct_in <= 2'h1;
    cyc(8);
    chk("awake", 32'h0, {31'h0, sleep});
    chk("low input off", 32'h0, {31'h0, sw[1]});
    conclude();
  end
endmodule // dsc_ctrl_tb

// *** tb/dsc_host_model.sv ***
/*
  Serial host model facing the command port of the dual switch control logic.
  Assumes a 40 MHz clk_i; frames run with a 200 ns serial clock, mode 0.
*/
`timescale 1ns/1ps
module dsc_host_model (
  // Clock.
  input wire logic clk_i,
  // Serial pins.
  input wire logic so_i,
  output logic sclk_o,
  output logic si_o,
  output logic chip_sel_n_o
);
  // Select idles high and the serial clock stands low outside frames.
  initial begin
    sclk_o = 1'b0;
    si_o = 1'b0;
    chip_sel_n_o = 1'b1;
  end

  // Sends the top nbits of word MSB first and gathers what SO shows before each rise.
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] reply);
    reply = 16'h0000;
    @(posedge clk_i) chip_sel_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < nbits; i++) begin
      si_o <= word[15 - i];
      repeat (4) @(posedge clk_i);
      reply = {reply[14:0], so_i};
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    // The data line is driven back low after the last bit, not released.
    si_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    chip_sel_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // dsc_host_model
